// ==== design/thsr_tx_hdlc_slot_routing.sv ====
// transmit hdlc bit routing into e1 sa bits or timeslots
// one frame bit position is presented per frame_bit_en strobe; the
// routed bit, its strobe and the inserted flag follow one cycle later.
// hdlc bits wait in a small fifo so the controller can run ahead of the
// slot timing. a picked position that finds the fifo empty sends the
// framer bit instead; the controller only sees a slower drain.
// the channel block map arrives as a port from its own registers.
module thsr_tx_hdlc_slot_routing
  import thsr_pkg::*;
#(
  parameter int FIFO_DEPTH = THSR_FIFO_DEPTH
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  // parallel control port
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // channel block map from its own registers
  input  wire logic [THSR_SLOTS-1:0] tx_channel_block_map,
  // hdlc controller serial bits
  input  wire logic                  hdlc_valid,
  output logic                       hdlc_ready,
  input  wire logic                  hdlc_bit,
  // framer bit stream position and data
  input  wire logic                  frame_bit_en,
  input  wire logic [4:0]            frame_slot,
  input  wire logic [2:0]            frame_bit_pos,
  input  wire logic                  frame_nat_slot,
  input  wire logic                  framer_bit,
  output logic                       tx_bit,
  output logic                       tx_bit_valid,
  output logic                       hdlc_inserted
);
  // elaboration checks: the buffer needs two places at least, and the
  // five-bit slot number field can only name 32 timeslots
  if (FIFO_DEPTH < 2) begin : g_depth_check
    $error("thsr: fifo depth too small");
  end
  if (THSR_SLOTS != 32) begin : g_slots_check
    $error("thsr: slot map must cover 32 timeslots");
  end

  // control register group
  logic [7:0] route_control;                 // enable, routing, slot field
  logic [7:0] next_route_control;
  logic [7:0] slot_bit_mask;                 // one suppress bit per position
  logic [7:0] next_slot_bit_mask;
  logic       wr_route_control;              // write strobes per register
  logic       wr_slot_bit_mask;
  // output group
  logic       next_tx_bit;
  logic       next_tx_bit_valid;
  logic       next_hdlc_inserted;
  // buffer side
  logic       fifo_valid;                    // a buffered hdlc bit waits
  logic       fifo_bit;
  logic       take;                          // pop: bit goes on the line
  logic       pick;                          // position may carry hdlc
  // decoded control fields
  logic       tx_hdlc_enable;
  logic       tx_route_national_or_slot;
  logic       tx_slot_pick_mode;
  logic [4:0] tx_slot_number;

  // bit 7 of a field covers the first transmitted bit (msb, position 0);
  // used for the suppress mask and for the sa field alike
  function automatic logic [2:0] mask_index(input logic [2:0] pos);
    mask_index = 3'(3'd7 - pos);
  endfunction : mask_index

  // field views of the route control register
  assign tx_hdlc_enable            = route_control[THSR_ENABLE_BIT];
  assign tx_route_national_or_slot = route_control[THSR_NAT_OR_SLOT];
  assign tx_slot_pick_mode         = route_control[THSR_PICK_MODE];
  assign tx_slot_number =
    route_control[THSR_SLOT_NUM_MSB:THSR_SLOT_NUM_LSB];

  // bits buffered so the controller can run ahead of the slot timing
  thsr_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (hdlc_valid),
    .in_ready  (hdlc_ready),
    .in_data   (hdlc_bit),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_bit)
  );

  // sa mode: field bit 4 enables sa4 at position 3 ... bit 0 sa8 at 7;
  // only the national-bit slot carries sa bits
  function automatic logic nat_picked(
    input logic [4:0] field,
    input logic [2:0] pos,
    input logic       nat
  );
    nat_picked = 1'b0;
    if (nat && pos >= 3'd3)
      nat_picked = field[mask_index(pos)];
  endfunction : nat_picked

  // timeslot mode: one slot by number, or every slot set in the map
  function automatic logic slot_routed(
    input logic                  mode,
    input logic [4:0]            number,
    input logic [THSR_SLOTS-1:0] map,
    input logic [4:0]            slot
  );
    if (!mode)
      slot_routed = (slot == number);
    else
      slot_routed = map[slot];
  endfunction : slot_routed

  // an hdlc bit is consumed only where one may be inserted; the enable
  // gates everything, so the routing select is don't-care while off
  always_comb begin
    pick = 1'b0;
    if (frame_bit_en && tx_hdlc_enable) begin
      if (!tx_route_national_or_slot) begin
        pick = nat_picked(tx_slot_number, frame_bit_pos, frame_nat_slot);
      end else if (!slot_bit_mask[mask_index(frame_bit_pos)]) begin
        pick = slot_routed(tx_slot_pick_mode, tx_slot_number,
                           tx_channel_block_map, frame_slot);
      end
    end
  end

  // an empty fifo on a picked position falls back to framer data, so an
  // underrun shows as a gap in the hdlc stream rather than stale bits
  assign take = pick && fifo_valid;

  // write decode: a strobe to any other address leaves both untouched
  assign wr_route_control = reg_wr && (reg_addr == THSR_ROUTE_CONTROL_OFS);
  assign wr_slot_bit_mask = reg_wr && (reg_addr == THSR_SLOT_BIT_MASK_OFS);

  // control next values; a write applies to frame bits from the next edge
  always_comb begin
    next_route_control = route_control;
    next_slot_bit_mask = slot_bit_mask;
    if (wr_route_control) begin
      next_route_control = reg_wdata;
    end
    if (wr_slot_bit_mask) begin
      next_slot_bit_mask = reg_wdata;
    end
  end

  // reads are combinational; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr)
      THSR_ROUTE_CONTROL_OFS: reg_rdata = route_control;
      THSR_SLOT_BIT_MASK_OFS: reg_rdata = slot_bit_mask;
      default:                reg_rdata = 8'h00;
    endcase
  end

  // output bit: hdlc where taken, framer data otherwise; tx_bit holds
  // its last value between strobes so the framer may sample it late
  always_comb begin
    next_tx_bit        = tx_bit;
    next_tx_bit_valid  = frame_bit_en;
    next_hdlc_inserted = 1'b0;
    if (frame_bit_en) begin
      next_tx_bit = take ? fifo_bit : framer_bit;
      next_hdlc_inserted = take;
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      route_control <= THSR_ROUTE_CONTROL_RST;
      slot_bit_mask <= THSR_SLOT_BIT_MASK_RST;
    end else begin
      route_control <= next_route_control;
      slot_bit_mask <= next_slot_bit_mask;
    end
  end

  // output registers: every output is one cycle behind its strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_bit        <= 1'b0;
      tx_bit_valid  <= 1'b0;
      hdlc_inserted <= 1'b0;
    end else begin
      tx_bit        <= next_tx_bit;
      tx_bit_valid  <= next_tx_bit_valid;
      hdlc_inserted <= next_hdlc_inserted;
    end
  end
endmodule : thsr_tx_hdlc_slot_routing

// ==== shared/thsr_pkg.sv ====
// package: register map, field positions and frame constants for slot routing
package thsr_pkg;
  // register offsets on the parallel control port
  localparam logic [7:0] THSR_ROUTE_CONTROL_OFS = 8'hba;
  localparam logic [7:0] THSR_SLOT_BIT_MASK_OFS = 8'hbb;
  // reset values
  localparam logic [7:0] THSR_ROUTE_CONTROL_RST = 8'h00;
  localparam logic [7:0] THSR_SLOT_BIT_MASK_RST = 8'h00;
  // route control field positions
  localparam int THSR_ENABLE_BIT    = 7;
  localparam int THSR_NAT_OR_SLOT   = 6;
  localparam int THSR_PICK_MODE     = 5;
  localparam int THSR_SLOT_NUM_MSB  = 4;
  localparam int THSR_SLOT_NUM_LSB  = 0;
  // frame geometry
  localparam int THSR_SLOTS         = 32;
  localparam int THSR_SLOT_BITS     = 8;
  localparam int THSR_NAT_BITS      = 5;
  localparam int THSR_FIFO_DEPTH    = 8;
endpackage : thsr_pkg

// ==== design/thsr_fifo.sv ====
// small synchronous FIFO with valid/ready on both sides
module thsr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // elaboration check: pointer wrap arithmetic needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("thsr_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic             push, pop;

  // full and empty from pointer difference, extra bit tells wrap
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer next values
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // pointers and storage
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : thsr_fifo

// ==== verif/thsr_framer_model.sv ====
// partner: framer stepping through slot bit positions with random gaps
module thsr_framer_model (
  input  wire logic       clock,
  input  wire logic       rst,
  output logic            frame_bit_en,
  output logic      [4:0] frame_slot,
  output logic      [2:0] frame_bit_pos,
  output logic            frame_nat_slot,
  output logic            framer_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] step;
  // slot zero carries the national bits at positions 3..7
  assign frame_slot     = step[7:3];
  assign frame_bit_pos  = step[2:0];
  assign frame_nat_slot = (step[7:3] == 5'h00);
  initial {frame_bit_en, framer_bit, step} = 10'h000;
  // gaps between strobes so pacing is not taken for granted
  always @(posedge clock) begin
    frame_bit_en <= !rst && ($urandom_range(3) != 0);
    framer_bit <= 1'($urandom);
    if (rst) step <= 8'h00;
    else if (frame_bit_en) step <= step + 8'h01;
  end
endmodule : thsr_framer_model

// ==== verif/thsr_sva.sv ====
// checker: routing assertions on the slot routing ports
module thsr_sva
  import thsr_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_wr,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic [THSR_SLOTS-1:0] tx_channel_block_map,
  input wire logic                  frame_bit_en,
  input wire logic [4:0]            frame_slot,
  input wire logic [2:0]            frame_bit_pos,
  input wire logic                  frame_nat_slot,
  input wire logic                  framer_bit,
  input wire logic                  tx_bit,
  input wire logic                  tx_bit_valid,
  input wire logic                  hdlc_inserted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl, next_ctl, msk, next_msk;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // shadow registers rebuilt from the write strobe alone
  assign next_ctl = (reg_wr && reg_addr == THSR_ROUTE_CONTROL_OFS) ?
                    reg_wdata : ctl;
  assign next_msk = (reg_wr && reg_addr == THSR_SLOT_BIT_MASK_OFS) ?
                    reg_wdata : msk;
  always_ff @(posedge clock) begin
    ctl <= rst ? THSR_ROUTE_CONTROL_RST : next_ctl;
    msk <= rst ? THSR_SLOT_BIT_MASK_RST : next_msk;
  end
  AST_INS_ENABLED: assert property (
    hdlc_inserted |-> tx_bit_valid && $past(ctl[7]))
    else $error("hdlc bit inserted while disabled");
  AST_VALID_LAT: assert property (
    tx_bit_valid == $past(frame_bit_en))
    else $error("output strobe not one cycle after position");
  AST_PASS_THRU: assert property (
    tx_bit_valid && !hdlc_inserted |-> tx_bit == $past(framer_bit))
    else $error("framer bit altered");
  // the suppress mask applies to timeslot routing only
  AST_MASK_POS: assert property (
    hdlc_inserted && $past(ctl[6]) |-> !$past(msk[~frame_bit_pos]))
    else $error("suppressed position carried hdlc");
  AST_SA_PICK: assert property (hdlc_inserted && !$past(ctl[6]) |->
    $past(frame_nat_slot && frame_bit_pos > 3'h2 && ctl[~frame_bit_pos]))
    else $error("national bit not picked");
  AST_ONE_SLOT: assert property (hdlc_inserted && $past(ctl[6:5]) == 2'h2 |->
    $past(frame_slot) == $past(ctl[4:0]))
    else $error("wrong single slot");
  AST_MAP_SLOT: assert property (hdlc_inserted && $past(ctl[6:5]) == 2'h3 |->
    $past(tx_channel_block_map[frame_slot]))
    else $error("slot outside block map");
  AST_READBACK: assert property (
    reg_addr == THSR_ROUTE_CONTROL_OFS |-> reg_rdata == ctl)
    else $error("route control readback differs");
  COV_SA: cover property (hdlc_inserted && !$past(ctl[6]));
  COV_ONE: cover property (hdlc_inserted && $past(ctl[6:5]) == 2'h2);
  COV_MAP: cover property (hdlc_inserted && $past(ctl[6:5]) == 2'h3);
endmodule : thsr_sva
bind thsr_tx_hdlc_slot_routing thsr_sva u_sva (.*);

// ==== verif/test_tx_hdlc_slot_routing.sv ====
// testbench: random routing setups against a queue scoreboard
module test_tx_hdlc_slot_routing
  import thsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, reg_wr = 0, hdlc_valid = 0, hdlc_bit = 0;
  logic        fill = 0, pick, hdlc_ready, frame_bit_en, frame_nat_slot;
  logic        framer_bit, tx_bit, tx_bit_valid, hdlc_inserted;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ctl, msk, c;
  logic [31:0] tx_channel_block_map = 32'h0000_0000;
  logic [4:0]  frame_slot;
  logic [2:0]  frame_bit_pos;
  logic [1:0]  e;
  logic        hq[$];
  logic [1:0]  eq[$];
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  thsr_tx_hdlc_slot_routing u_dut (.*);
  thsr_framer_model u_frm (.*);
  always #12.5 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    @(negedge clock);
    check(reg_rdata, d);
    @(posedge clock);
  endtask : rd
  // expected bit per position: pop the fifo image first, then push
  always @(posedge clock) begin
    // suppress mask only inside timeslots; sa bits are never masked
    pick = ctl[7] && (ctl[6] ? !msk[~frame_bit_pos] && (ctl[5] ?
      tx_channel_block_map[frame_slot] : frame_slot == ctl[4:0]) :
      frame_nat_slot && frame_bit_pos > 3'h2 && ctl[~frame_bit_pos]);
    if (frame_bit_en && !rst) begin
      if (pick && hq.size() > 0) eq.push_back({1'b1, hq.pop_front()});
      else eq.push_back({1'b0, framer_bit});
    end
    if (hdlc_valid && hdlc_ready && !rst) hq.push_back(hdlc_bit);
    if (rst) {ctl, msk} <= {THSR_ROUTE_CONTROL_RST, THSR_SLOT_BIT_MASK_RST};
    else if (reg_wr && reg_addr == THSR_ROUTE_CONTROL_OFS) ctl <= reg_wdata;
    else if (reg_wr && reg_addr == THSR_SLOT_BIT_MASK_OFS) msk <= reg_wdata;
    // an offered bit stays put until the fifo takes it
    if (rst || !hdlc_valid || hdlc_ready) begin
      hdlc_valid <= !rst && (fill || $urandom_range(1) != 0);
      hdlc_bit <= 1'($urandom);
    end
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      results();
    end
  end
  // outputs are judged mid-cycle, once settled
  always @(negedge clock) begin
    if (tx_bit_valid === 1'b1) begin
      e = eq.pop_front();
      check({6'h00, hdlc_inserted, tx_bit}, {6'h00, e});
    end
  end
  initial begin
    void'($urandom(36588));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(THSR_ROUTE_CONTROL_OFS, THSR_ROUTE_CONTROL_RST);
    rd(THSR_SLOT_BIT_MASK_OFS, THSR_SLOT_BIT_MASK_RST);
    // disabled: the fifo fills and refuses, nothing drains
    fill <= 1'b1;
    repeat (14) @(posedge clock);
    check({7'h00, hdlc_ready}, 8'h00);
    fill <= 1'b0;
    wr(8'hbc, 8'hff);
    rd(8'hbc, 8'h00);
    // off, national bits, one slot, block map, three rounds each
    for (int i = 0; i < 12; i++) begin
      c = 8'($urandom);
      c[7] = (i % 4 != 0);
      if (i % 4 == 1) c[6] = 1'b0;
      if (i % 4 > 1) c[6:5] = {1'b1, i % 4 == 3};
      tx_channel_block_map <= $urandom;
      wr(THSR_SLOT_BIT_MASK_OFS, 8'($urandom & $urandom));
      wr(THSR_ROUTE_CONTROL_OFS, c);
      rd(THSR_ROUTE_CONTROL_OFS, c);
      repeat (400) @(posedge clock);
    end
    results();
  end
endmodule : test_tx_hdlc_slot_routing
